// ---- hdl/sampler_pkg.sv ----
package sampler_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned WAIT_US = 1000;
  localparam int unsigned WAIT_CYCLES = CLK_HZ / 1_000_000 * WAIT_US;
  // sample period is 2**WIN_BITS clk cycles
  localparam int unsigned WIN_BITS = 16;

  localparam logic [7:0] OFS_CFG = 8'h01;
  localparam logic [7:0] OFS_CUR_A = 8'h05;
  localparam logic [7:0] OFS_CUR_B = 8'h06;
  localparam logic [7:0] OFS_SWRST = 8'h0F;
  localparam logic [7:0] OFS_CODE_LO = 8'h12;
  localparam logic [7:0] OFS_CODE_HI = 8'h13;
  localparam logic [7:0] OFS_FILT = 8'h50;

  localparam logic [7:0] RST_CFG = 8'h18;
  localparam logic [7:0] RST_CUR = 8'h1F;
  localparam logic [1:0] RST_FILT = 2'h0;
  localparam logic [7:0] CFG_WMASK = 8'h1F;

  localparam int unsigned BIT_HYST_FINE = 7;
  localparam int unsigned BIT_LB_DIS = 6;
  localparam int unsigned BIT_PWM_EN_A = 0;
  localparam int unsigned BIT_PWM_EN_B = 1;
  localparam int unsigned BIT_PWM_LOW = 2;
  localparam int unsigned BIT_SWRST = 0;

  localparam logic [7:0] ADDR8_SEL0 = 8'h36;
  localparam logic [7:0] ADDR8_SEL1 = 8'h38;

  localparam logic [7:0] HYST_COARSE = 8'h03;
  localparam logic [7:0] HYST_FINE = 8'h01;
  localparam logic [7:0] CODE_OFF_MAX = 8'h01;
  localparam logic [7:0] CODE_FLOOR = 8'h06;
  localparam logic [7:0] CODE_FULL = 8'hFF;

  typedef enum logic [3:0] {
    st_idle, st_addr, st_addr_ack, st_reg, st_reg_ack,
    st_wdata, st_wdata_ack, st_rdata, st_rd_ack, st_ignore
  } i2c_state_t;
endpackage

// ---- hdl/i2c_cfg_link.sv ----
module i2c_cfg_link (
  input wire logic link_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sel_in,
  input wire logic nak_lvl,
  input wire logic ack_tgl,
  input wire logic [7:0] rdata,
  output logic sda_out,
  output logic sda_oe,
  output logic bus_busy,
  output logic req_tgl,
  output logic req_wr,
  output logic [7:0] req_addr,
  output logic [7:0] req_data
);
  logic rst_m, rst_l;
  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  logic sel_m, sel_s, nak_m, nak_s, ack_m, ack_s, ack_p;
  logic [7:0] rd_l_q, shreg_q;
  logic [3:0] cnt_q;
  logic rw_q;
  sampler_pkg::i2c_state_t state_q;

  // async assert, clean release on the link clock
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      rst_m <= 1'b1;
      rst_l <= 1'b1;
    end else begin
      rst_m <= 1'b0;
      rst_l <= rst_m;
    end
  end

  always_ff @(posedge link_clk or posedge rst_l) begin
    if (rst_l) begin
      {scl_m, scl_s, scl_p, sda_m, sda_s, sda_p} <= 6'h3F;
      {sel_m, sel_s, nak_m, nak_s, ack_m, ack_s, ack_p} <= 7'h00;
    end else begin
      {scl_m, scl_s, scl_p} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {sda_in, sda_m, sda_s};
      {sel_m, sel_s, nak_m, nak_s} <= {sel_in, sel_m, nak_lvl, nak_m};
      {ack_m, ack_s, ack_p} <= {ack_tgl, ack_m, ack_s};
    end
  end

  wire scl_rise = scl_s & ~scl_p;
  wire scl_fall = ~scl_s & scl_p;
  // sda may only move while scl is low, so a move with scl high is a frame edge
  wire start_cond = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_cond = scl_s & scl_p & ~sda_p & sda_s;
  wire [7:0] my_addr = sel_s ? sampler_pkg::ADDR8_SEL1 : sampler_pkg::ADDR8_SEL0;
  wire addr_hit = (shreg_q[7:1] == my_addr[6:0]) & ~nak_s;
  wire byte_done = scl_fall & (cnt_q == 4'h8);

  // word is stable two link cycles before the toggle shows here
  always_ff @(posedge link_clk or posedge rst_l) begin
    if (rst_l) begin
      rd_l_q <= 8'h00;
    end else if (ack_s ^ ack_p) begin
      rd_l_q <= rdata;
    end
  end

  always_ff @(posedge link_clk or posedge rst_l) begin
    if (rst_l) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or posedge rst_l) begin
    if (rst_l) begin
      state_q <= sampler_pkg::st_idle;
      cnt_q <= 4'h0;
      shreg_q <= 8'h00;
      sda_oe <= 1'b0;
      bus_busy <= 1'b0;
      rw_q <= 1'b0;
      req_tgl <= 1'b0;
      req_wr <= 1'b0;
      req_addr <= 8'h00;
      req_data <= 8'h00;
    end else if (start_cond) begin
      state_q <= sampler_pkg::st_addr;
      cnt_q <= 4'h0;
      sda_oe <= 1'b0;
      bus_busy <= 1'b1;
    end else if (stop_cond) begin
      state_q <= sampler_pkg::st_idle;
      sda_oe <= 1'b0;
      bus_busy <= 1'b0;
    end else begin
      case (state_q)
        sampler_pkg::st_addr, sampler_pkg::st_reg, sampler_pkg::st_wdata: begin
          if (scl_rise) begin
            shreg_q <= {shreg_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            cnt_q <= 4'h0;
            if (state_q == sampler_pkg::st_addr) begin
              if (addr_hit) begin
                sda_oe <= 1'b1;
                rw_q <= shreg_q[0];
                state_q <= sampler_pkg::st_addr_ack;
              end else begin
                state_q <= sampler_pkg::st_ignore;
              end
            end else begin
              sda_oe <= 1'b1;
              req_tgl <= ~req_tgl;
              req_wr <= (state_q == sampler_pkg::st_wdata);
              if (state_q == sampler_pkg::st_reg) begin
                req_addr <= shreg_q;
                state_q <= sampler_pkg::st_reg_ack;
              end else begin
                req_data <= shreg_q;
                state_q <= sampler_pkg::st_wdata_ack;
              end
            end
          end
        end
        sampler_pkg::st_addr_ack, sampler_pkg::st_reg_ack, sampler_pkg::st_wdata_ack: begin
          if (scl_fall) begin
            if (state_q == sampler_pkg::st_addr_ack && rw_q) begin
              shreg_q <= rd_l_q;
              sda_oe <= ~rd_l_q[7];
              state_q <= sampler_pkg::st_rdata;
            end else begin
              sda_oe <= 1'b0;
              state_q <= (state_q == sampler_pkg::st_addr_ack) ? sampler_pkg::st_reg : sampler_pkg::st_wdata;
            end
          end
        end
        sampler_pkg::st_rdata: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            cnt_q <= 4'h0;
            sda_oe <= 1'b0;
            state_q <= sampler_pkg::st_rd_ack;
          end else if (scl_fall) begin
            shreg_q <= {shreg_q[6:0], 1'b0};
            sda_oe <= ~shreg_q[6];
          end
        end
        sampler_pkg::st_rd_ack: begin
          if (scl_rise && sda_s) begin
            state_q <= sampler_pkg::st_ignore;
          end else if (scl_fall) begin
            shreg_q <= rd_l_q;
            sda_oe <= ~rd_l_q[7];
            state_q <= sampler_pkg::st_rdata;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end
endmodule

// ---- hdl/pwm_duty_sampler_i2c_cfg.sv ----
// How it works
// - filter lets output change every 1/2/4/8 periods
// - default: change needs three codes of difference, except a drop to a measured code of one or zero
// - fine hysteresis bit allows single-code steps
// - lower bound: codes zero or one give zero
// - lower bound: codes two to six give six
// - lower bound: codes above six pass through
// - bound disabled: output follows hysteresis, low codes allowed
// - code one is about one 256th duty
// - default needs code three or more before turning on
// - sda changes only while scl low
// - busy from start to stop, repeated start same
// - bytes msb first, ack on ninth clock
// - acknowledge a matching address and every byte after it
// - seven-bit address plus direction bit
// - write: register select byte, then data byte
// - address pin picks 0x36 or 0x38
// - sampler code scales either bank's current
// - refuse transactions for 1 ms after soft reset
module pwm_duty_sampler_i2c_cfg #(
  parameter int unsigned WAIT_CYCLES = sampler_pkg::WAIT_CYCLES,
  parameter int unsigned WIN_BITS = sampler_pkg::WIN_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sel_in,
  input wire logic pwm_in,
  output logic sda_out,
  output logic sda_oe,
  output logic bus_busy,
  output logic [7:0] sampler_code,
  output logic [12:0] bank_a_level,
  output logic [12:0] bank_b_level
);
  localparam int unsigned WAIT_W = $clog2(WAIT_CYCLES + 1);
  localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(WAIT_CYCLES - 1);

  logic req_tgl;
  logic req_wr;
  logic ack_q;
  logic [7:0] req_addr;
  logic [7:0] req_data;
  logic [7:0] rdata_q;
  logic req_m, req_s, req_p;
  logic pend_q;
  logic nak_q;
  logic [WAIT_W-1:0] wait_cnt_q;
  logic [7:0] sampler_config_q;
  logic [7:0] bank_a_current_sampler_ctrl_q;
  logic [7:0] bank_b_current_q;
  logic [7:0] sel_q;
  logic [1:0] sampler_filter_strength_q;
  logic pwm_m;
  logic pwm_s;
  logic [WIN_BITS-1:0] win_cnt_q;
  logic [WIN_BITS-1:0] high_q;
  logic [7:0] meas_q;
  logic [7:0] hyst_q;
  logic sp_q;
  logic [2:0] per_cnt_q;

  i2c_cfg_link u_link (
    .link_clk(link_clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sel_in(sel_in),
    .nak_lvl(nak_q),
    .ack_tgl(ack_q),
    .rdata(rdata_q),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .bus_busy(bus_busy),
    .req_tgl(req_tgl),
    .req_wr(req_wr),
    .req_addr(req_addr),
    .req_data(req_data)
  );

  // request toggle crossing; addr and data held by the link until the next byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {req_m, req_s, req_p} <= 3'h0;
    end else begin
      {req_m, req_s, req_p} <= {req_tgl, req_m, req_s};
    end
  end

  wire req_evt = req_s ^ req_p;
  wire wr_evt = req_evt & req_wr;
  wire hit_cfg = req_addr == sampler_pkg::OFS_CFG;
  wire hit_cur_a = req_addr == sampler_pkg::OFS_CUR_A;
  wire hit_cur_b = req_addr == sampler_pkg::OFS_CUR_B;
  wire hit_filt = req_addr == sampler_pkg::OFS_FILT;
  wire swrst_evt = wr_evt & (req_addr == sampler_pkg::OFS_SWRST) & req_data[sampler_pkg::BIT_SWRST];
  wire fine_hyst = bank_a_current_sampler_ctrl_q[sampler_pkg::BIT_HYST_FINE];
  wire lb_en = ~bank_a_current_sampler_ctrl_q[sampler_pkg::BIT_LB_DIS];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sampler_config_q <= sampler_pkg::RST_CFG;
      bank_a_current_sampler_ctrl_q <= sampler_pkg::RST_CUR;
      bank_b_current_q <= sampler_pkg::RST_CUR;
      sampler_filter_strength_q <= sampler_pkg::RST_FILT;
    end else if (swrst_evt) begin
      sampler_config_q <= sampler_pkg::RST_CFG;
      bank_a_current_sampler_ctrl_q <= sampler_pkg::RST_CUR;
      bank_b_current_q <= sampler_pkg::RST_CUR;
      sampler_filter_strength_q <= sampler_pkg::RST_FILT;
    end else if (wr_evt) begin
      if (hit_cfg) begin
        sampler_config_q <= req_data & sampler_pkg::CFG_WMASK;
      end else if (hit_cur_a) begin
        bank_a_current_sampler_ctrl_q <= req_data;
      end else if (hit_cur_b) begin
        bank_b_current_q <= req_data;
      end else if (hit_filt) begin
        sampler_filter_strength_q <= req_data[1:0];
      end
    end
  end

  // read value is a snapshot taken right after the select or write
  wire [7:0] rd_mux = (sel_q == sampler_pkg::OFS_CFG) ? sampler_config_q :
                      (sel_q == sampler_pkg::OFS_CUR_A) ? bank_a_current_sampler_ctrl_q :
                      (sel_q == sampler_pkg::OFS_CUR_B) ? bank_b_current_q :
                      (sel_q == sampler_pkg::OFS_FILT) ? {6'h00, sampler_filter_strength_q} :
                      (sel_q == sampler_pkg::OFS_CODE_LO) ? sampler_code : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_q <= 8'h00;
      pend_q <= 1'b0;
    end else begin
      sel_q <= req_evt ? req_addr : sel_q;
      pend_q <= req_evt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
      ack_q <= 1'b0;
    end else if (pend_q) begin
      rdata_q <= rd_mux;
      ack_q <= ~ack_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nak_q <= 1'b0;
      wait_cnt_q <= '0;
    end else if (swrst_evt) begin
      nak_q <= 1'b1;
      wait_cnt_q <= '0;
    end else if (nak_q) begin
      nak_q <= wait_cnt_q != WAIT_LAST;
      wait_cnt_q <= wait_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_m <= 1'b0;
      pwm_s <= 1'b0;
    end else begin
      pwm_m <= pwm_in;
      pwm_s <= pwm_m;
    end
  end

  // duty over a fixed window, 256 codes full scale; slow pwm aliases into visible steps
  wire lvl = pwm_s ^ sampler_config_q[sampler_pkg::BIT_PWM_LOW];
  wire win_end = &win_cnt_q;
  wire [WIN_BITS:0] total = {1'b0, high_q} + {{WIN_BITS{1'b0}}, lvl};
  wire [7:0] meas_d = total[WIN_BITS] ? sampler_pkg::CODE_FULL : total[WIN_BITS-1 -: 8];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_cnt_q <= '0;
      high_q <= '0;
      meas_q <= 8'h00;
      sp_q <= 1'b0;
    end else begin
      win_cnt_q <= win_cnt_q + 1'b1;
      high_q <= win_end ? '0 : total[WIN_BITS-1:0];
      meas_q <= win_end ? meas_d : meas_q;
      sp_q <= win_end;
    end
  end

  wire [2:0] filt_mask = {&sampler_filter_strength_q, sampler_filter_strength_q[1], |sampler_filter_strength_q};
  wire upd_ok = sp_q & ((per_cnt_q & filt_mask) == filt_mask);
  wire [7:0] thr = fine_hyst ? sampler_pkg::HYST_FINE : sampler_pkg::HYST_COARSE;
  wire go_up = {1'b0, meas_q} >= ({1'b0, hyst_q} + {1'b0, thr});
  wire go_down = {1'b0, hyst_q} >= ({1'b0, meas_q} + {1'b0, thr});
  wire to_off = lb_en & (meas_q <= sampler_pkg::CODE_OFF_MAX);
  wire hyst_take = upd_ok & (go_up | go_down | to_off);
  wire [7:0] code_d = ~lb_en ? hyst_q :
                      (hyst_q <= sampler_pkg::CODE_OFF_MAX) ? 8'h00 :
                      (hyst_q <= sampler_pkg::CODE_FLOOR) ? sampler_pkg::CODE_FLOOR : hyst_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      per_cnt_q <= 3'h0;
      hyst_q <= 8'h00;
      sampler_code <= 8'h00;
    end else begin
      per_cnt_q <= sp_q ? per_cnt_q + 3'h1 : per_cnt_q;
      hyst_q <= hyst_take ? meas_q : hyst_q;
      sampler_code <= code_d;
    end
  end

  // a bank without pwm enabled keeps its full programmed current
  wire [7:0] mul_a = sampler_config_q[sampler_pkg::BIT_PWM_EN_A] ? sampler_code : sampler_pkg::CODE_FULL;
  wire [7:0] mul_b = sampler_config_q[sampler_pkg::BIT_PWM_EN_B] ? sampler_code : sampler_pkg::CODE_FULL;
  wire [12:0] lvl_a = {8'h00, bank_a_current_sampler_ctrl_q[4:0]} * {5'h00, mul_a};
  wire [12:0] lvl_b = {8'h00, bank_b_current_q[4:0]} * {5'h00, mul_b};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank_a_level <= 13'h0000;
      bank_b_level <= 13'h0000;
    end else begin
      bank_a_level <= lvl_a;
      bank_b_level <= lvl_b;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_FILTER_GAP: assert property (hyst_q != $past(hyst_q) |-> $past(upd_ok))
    else $error("sampler changed outside a filter slot");
  AST_FILTER_SLOT: assert property (sp_q && sampler_filter_strength_q == 2'h3 && per_cnt_q != 3'h7 |-> !upd_ok)
    else $error("strongest filter allowed an early update");
  AST_HYST_COARSE: assert property (upd_ok && !fine_hyst && meas_q > hyst_q && !to_off
    && ({1'b0, meas_q} < {1'b0, hyst_q} + 9'h003) |=> $stable(hyst_q))
    else $error("sampler rose on less than three codes");
  AST_HYST_RISE: assert property (upd_ok && !fine_hyst && ({1'b0, meas_q} >= {1'b0, hyst_q} + 9'h003)
    |=> hyst_q == $past(meas_q))
    else $error("sampler missed a three code rise");
  AST_HYST_FINE: assert property (upd_ok && fine_hyst && meas_q != hyst_q |=> hyst_q == $past(meas_q))
    else $error("fine hysteresis did not follow one code");
  AST_LB_OFF: assert property (lb_en && hyst_q <= 8'h01 |=> sampler_code == 8'h00)
    else $error("low code not forced off");
  AST_LB_SIX: assert property (lb_en && hyst_q >= 8'h02 && hyst_q <= 8'h06 |=> sampler_code == 8'h06)
    else $error("low code not raised to six");
  AST_LB_PASS: assert property (lb_en && hyst_q > 8'h06 |=> sampler_code == $past(hyst_q))
    else $error("code above six altered");
  AST_LB_DIS: assert property (!lb_en ##1 1'b1 |-> sampler_code == $past(hyst_q))
    else $error("disabled bound still clamps");
  AST_NAK_START: assert property (swrst_evt |=> nak_q [*8])
    else $error("refusal window did not open");
  AST_NAK_END: assert property (nak_q && wait_cnt_q == WAIT_LAST && !swrst_evt |=> !nak_q)
    else $error("refusal window did not close");
  AST_SCALE_A: assert property (sampler_config_q[0] |=> bank_a_level ==
    13'($past(bank_a_current_sampler_ctrl_q[4:0]) * $past(sampler_code)))
    else $error("bank a not scaled by sampler code");
  AST_FILTER_NONE: assert property (sp_q && sampler_filter_strength_q == 2'h0 |-> upd_ok)
    else $error("weakest filter skipped a sample period");
  AST_MEAS_HOLD: assert property (!win_end |=> $stable(meas_q))
    else $error("measurement moved inside a window");
  AST_HYST_FALL: assert property (upd_ok && !fine_hyst && meas_q < hyst_q && !to_off
    && ({1'b0, hyst_q} < {1'b0, meas_q} + 9'h003) |=> $stable(hyst_q))
    else $error("sampler fell on less than three codes");
  AST_LB_TAKE_OFF: assert property (upd_ok && to_off |=> hyst_q == $past(meas_q))
    else $error("off request not taken");
  AST_WRITE_LAND: assert property (wr_evt && hit_cur_a
    |=> bank_a_current_sampler_ctrl_q == $past(req_data))
    else $error("bank a write lost");
  AST_CFG_WRITE: assert property (wr_evt && hit_cfg
    |=> sampler_config_q == ($past(req_data) & sampler_pkg::CFG_WMASK))
    else $error("config write lost");
  AST_SEL_SNAP: assert property (req_evt |=> sel_q == $past(req_addr))
    else $error("register select not kept");
  AST_RD_SNAP: assert property (pend_q |=> rdata_q == $past(rd_mux))
    else $error("read snapshot not taken");
  AST_NAK_HOLD: assert property (nak_q && wait_cnt_q != WAIT_LAST |=> nak_q)
    else $error("refusal window closed early");
  AST_SWRST_DEFAULT: assert property (swrst_evt |=> bank_a_current_sampler_ctrl_q == sampler_pkg::RST_CUR
    && sampler_filter_strength_q == sampler_pkg::RST_FILT)
    else $error("soft reset left settings");
  AST_SCALE_B: assert property (sampler_config_q[1] |=> bank_b_level ==
    13'($past(bank_b_current_q[4:0]) * $past(sampler_code)))
    else $error("bank b not scaled by sampler code");
  AST_FULL_A: assert property (!sampler_config_q[0] |=> bank_a_level ==
    13'($past(bank_a_current_sampler_ctrl_q[4:0]) * 8'hFF))
    else $error("bank a without pwm not at full scale");

  COV_UPDATE: cover property (upd_ok && hyst_take);
  COV_FLOOR: cover property (lb_en && sampler_code == 8'h06);
  COV_SWRST: cover property (swrst_evt ##1 nak_q);
  COV_WRITE: cover property (wr_evt && hit_cur_a);
  COV_FINE: cover property (upd_ok && fine_hyst && hyst_take);
endmodule

// ---- tb/i2c_pwm_partner.sv ----
module i2c_pwm_partner (
  input wire logic clk,
  input wire logic link_clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda,
  output logic pwm
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 8;
  logic scl_q;
  logic low_q;
  logic pwm_q = 1'b0;
  logic [8:0] pwm_cnt = 9'h000;
  logic [9:0] hi_q = 10'h000;
  logic [9:0] hi_next = 10'h000;
  // open drain: a released line floats up through the pull-up
  assign sda = ~(low_q | sda_oe);
  assign scl = scl_q;
  initial begin
    scl_q = 1'b1;
    low_q = 1'b0;
  end
  assign pwm = pwm_q;
  // 512 clk period, about 48.8 kHz, inside the allowed band
  always @(posedge clk) begin
    pwm_cnt <= pwm_cnt + 9'h001;
    pwm_q <= ({1'b0, pwm_cnt} < hi_q);
    if (pwm_cnt == 9'h1FF) begin
      hi_q <= hi_next;
    end
  end
  // duty switches at a period boundary so windows see whole periods
  task automatic set_duty(input logic [7:0] code);
    hi_next <= {1'b0, code, 1'b0};
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  // also serves as repeated start: sda released while scl is low first
  task automatic start_cond();
    @(posedge link_clk);
    low_q <= 1'b0;
    tick(HALF);
    scl_q <= 1'b1;
    tick(HALF);
    low_q <= 1'b1; // sda falls while scl high
    tick(HALF);
    scl_q <= 1'b0;
  endtask
  task automatic stop_cond();
    @(posedge link_clk);
    low_q <= 1'b1;
    tick(HALF);
    scl_q <= 1'b1;
    tick(HALF);
    low_q <= 1'b0; // sda rises while scl high
    tick(HALF);
  endtask
  task automatic xfer_bit(input logic b, output logic r, output logic stable);
    @(posedge link_clk);
    low_q <= ~b; // data moves only while scl is low
    tick(HALF);
    scl_q <= 1'b1;
    tick(2);
    @(negedge link_clk);
    r = sda;
    tick(HALF - 3);
    @(negedge link_clk);
    stable = (sda === r);
    tick(1);
    scl_q <= 1'b0;
  endtask
  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx, output logic ack, output logic stable);
    logic b;
    logic s;
    stable = 1'b1;
    for (int i = 7; i >= 0; i--) begin // msb first
      xfer_bit(tx[i], rx[i], s);
      stable &= s;
    end
    xfer_bit(1'b1, b, s); // master lets go on the ninth clock
    stable &= s;
    ack = ~b;
  endtask
endmodule

// ---- tb/pwm_duty_sampler_i2c_cfg_tb_top.sv ----
module pwm_duty_sampler_i2c_cfg_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAITC = 2000;
  localparam int WIN = 1024;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst;
  logic sel_in;
  localparam logic [7:0] ADDR_WR = {sampler_pkg::ADDR8_SEL0[6:0], 1'b0};
  localparam logic [7:0] ADDR_ALT = {sampler_pkg::ADDR8_SEL1[6:0], 1'b0};
  logic scl, sda, pwm, sda_out, sda_oe, bus_busy;
  logic [7:0] sampler_code;
  logic [12:0] bank_a_level;
  logic [12:0] bank_b_level;
  logic [7:0] rx;
  logic ack, stab;
  int gap;
  int miscompares = 0;
  int check_count = 0;

  always #20 clk = ~clk;
  always #24 link_clk = ~link_clk;

  // short window and refusal time keep the run small
  pwm_duty_sampler_i2c_cfg #(.WAIT_CYCLES(WAITC), .WIN_BITS(10)) i_pwm_duty_sampler_i2c_cfg (
    .clk(clk), .rst(rst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda), .sel_in(sel_in),
    .pwm_in(pwm), .sda_out(sda_out), .sda_oe(sda_oe), .bus_busy(bus_busy),
    .sampler_code(sampler_code), .bank_a_level(bank_a_level), .bank_b_level(bank_b_level)
  );
  i2c_pwm_partner u_master (
    .clk(clk), .link_clk(link_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda), .pwm(pwm)
  );

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic send(input logic [7:0] b, input logic exp_ack);
    u_master.xfer_byte(b, rx, ack, stab);
    check("ack", 16'(ack), 16'(exp_ack));
  endtask
  task automatic probe(input logic [7:0] adr, input logic exp_ack);
    u_master.start_cond();
    send(adr, exp_ack);
    u_master.stop_cond();
  endtask
  task automatic reg_write(input logic [7:0] r, input logic [7:0] d);
    u_master.start_cond();
    @(negedge link_clk);
    check("bus_busy", 16'(bus_busy), 16'h0001);
    send(ADDR_WR, 1'b1);
    send(r, 1'b1);
    send(d, 1'b1);
    u_master.stop_cond();
    repeat (6) @(negedge link_clk);
    check("bus_busy", 16'(bus_busy), 16'h0000);
  endtask
  task automatic reg_read(input logic [7:0] r, input logic [7:0] exp);
    u_master.start_cond();
    send(ADDR_WR, 1'b1);
    send(r, 1'b1);
    u_master.start_cond();
    @(negedge link_clk);
    check("bus_busy", 16'(bus_busy), 16'h0001);
    send(ADDR_WR | 8'h01, 1'b1);
    u_master.xfer_byte(8'hFF, rx, ack, stab);
    check("rdata", 16'(rx), 16'(exp));
    check("sda_stable", 16'(stab), 16'h0001);
    check("sda_out", 16'(sda_out), 16'h0000);
    u_master.stop_cond();
  endtask
  task automatic wait_code(input logic [7:0] exp);
    int n;
    n = 0;
    while (sampler_code !== exp && n < 8 * WIN) begin
      @(negedge clk);
      n++;
    end
    check("sampler_code", 16'(sampler_code), 16'(exp));
    if (n >= 8 * WIN) tally_and_finish();
  endtask
  task automatic wait_change(output int n);
    logic [7:0] c0;
    c0 = sampler_code;
    n = 0;
    while (sampler_code === c0 && n < 12 * WIN) begin
      @(negedge clk);
      n++;
    end
    if (n >= 12 * WIN) begin
      miscompares++;
      tally_and_finish();
    end
  endtask

  initial begin
    rst = 1'b1;
    sel_in = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge link_clk);
    @(negedge clk);
    check("sampler_code", 16'(sampler_code), 16'h0000);
    check("bank_a_level", 16'(bank_a_level), 16'h1EE1);
    reg_read(sampler_pkg::OFS_CUR_A, 8'h1F);
    reg_read(sampler_pkg::OFS_FILT, 8'h00);
    reg_read(8'h30, 8'h00);
    reg_write(sampler_pkg::OFS_FILT, 8'h03);
    reg_read(sampler_pkg::OFS_FILT, 8'h03);
    reg_write(sampler_pkg::OFS_FILT, 8'h00);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      sel_in <= 1'(s);
      repeat (6) @(posedge link_clk);
      probe(ADDR_WR, s == 0);
      probe(ADDR_ALT, s == 1);
    end
    @(posedge clk);
    sel_in <= 1'b0;
    reg_write(sampler_pkg::OFS_CFG, 8'h19);
    u_master.set_duty(8'h04);
    wait_code(8'h06);
    u_master.set_duty(8'h28);
    wait_code(8'h28);
    repeat (2) @(negedge clk);
    check("bank_a_level", 16'(bank_a_level), 16'h04D8);
    check("bank_b_level", 16'(bank_b_level), 16'h1EE1);
    u_master.set_duty(8'h2A);
    repeat (3 * WIN) @(negedge clk);
    check("sampler_code", 16'(sampler_code), 16'h0028);
    u_master.set_duty(8'h2B);
    wait_code(8'h2B);
    u_master.set_duty(8'h01);
    wait_code(8'h00);
    reg_write(sampler_pkg::OFS_CUR_A, 8'h9F);
    u_master.set_duty(8'h2C);
    wait_code(8'h2C);
    u_master.set_duty(8'h2D);
    wait_code(8'h2D);
    reg_write(sampler_pkg::OFS_CUR_A, 8'hDF);
    u_master.set_duty(8'h01);
    wait_code(8'h01);
    u_master.set_duty(8'h03);
    wait_code(8'h03);
    // the second change is requested right after the first lands, so its gap is the filter stride
    for (int f = 0; f < 4; f++) begin
      reg_write(sampler_pkg::OFS_FILT, 8'(f));
      u_master.set_duty(8'h50);
      wait_change(gap);
      u_master.set_duty(8'h28);
      wait_change(gap);
      check("update_gap", 16'((gap + 128) / 256), 16'((WIN << f) / 256));
    end
    reg_write(sampler_pkg::OFS_FILT, 8'h00);
    reg_write(sampler_pkg::OFS_CFG, 8'h1E);
    wait_code(8'hD8);
    repeat (2) @(negedge clk);
    check("bank_b_level", 16'(bank_b_level), 16'h1A28);
    check("bank_a_level", 16'(bank_a_level), 16'h1EE1);
    reg_write(sampler_pkg::OFS_SWRST, 8'h01);
    probe(ADDR_WR, 1'b0);
    repeat (WAITC) @(posedge clk);
    reg_read(sampler_pkg::OFS_CUR_A, 8'h1F);
    tally_and_finish();
  end
endmodule
